// [hdl/accc_pkg.sv]
// ============================================================
// Shared constants for the auto clock calibrator
// ============================================================
package accc_pkg;

  // Widths
  localparam int CNT_W  = 16;  // Sample counter width
  localparam int STEP_W = 4;   // Trim step width
  localparam int CT_W   = 8;   // Coarse trim width
  localparam int FT_W   = 6;   // Fine trim width

  // Reset values and ceilings of the trim outputs
  localparam logic [CT_W-1:0] COARSE_RST = 8'h80;  // Mid-scale coarse
  localparam logic [FT_W-1:0] FINE_RST   = 6'h20;  // Fine default 32
  localparam logic [CT_W-1:0] COARSE_MAX = 8'hFF;  // Coarse ceiling
  localparam logic [FT_W-1:0] FINE_MAX   = 6'h3F;  // Fine ceiling

  // Timing of the reference
  localparam int SOF_PERIOD_US  = 1000;        // Frame period, 1 ms
  localparam int REF_CLK_HZ     = 10000000;    // System clock rate
  localparam int SOF_HIGH_CYC   = 12;          // Reference pulse width
  localparam int SOF_PERIOD_CYC = (REF_CLK_HZ / 1000000) * SOF_PERIOD_US;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,  // Waiting for a trigger
    ST_MEASURE = 2'b01,  // Taking the first full period
    ST_CROSS   = 2'b10   // Stepping until the centre is crossed
  } accc_state_t;

endpackage

// [hdl/accc_sample_counter.sv]
`timescale 1ns/1ps
// ============================================================
// Sample counter: counts divided oscillator edges per frame
// ============================================================
module accc_sample_counter
  import accc_pkg::*;
(
  input  wire logic             clk_i,      // System clock
  input  wire logic             rst_b_i,    // Sync reset, low
  input  wire logic             div_clk_i,  // Divided oscillator, async
  input  wire logic             sof_i,      // Frame reference pulse
  output logic                  sof_rise_o, // First cycle of a frame
  output logic [CNT_W-1:0]      live_o,     // Running count
  output logic [CNT_W-1:0]      sample_o,   // Count of last period
  output logic                  valid_o     // Sample_o just updated
);

  // ============================================================
  // State
  // ============================================================
  logic             sync1_ff, sync2_ff, div_d_ff; // Synchroniser, edge
  logic             sof_d_ff;                     // Delayed reference
  logic [CNT_W-1:0] cnt_ff, samp_ff;              // Counter, capture
  logic             vld_ff;                       // Capture strobe
  logic             nxt_div_d, nxt_sof_d, nxt_vld;
  logic [CNT_W-1:0] nxt_cnt, nxt_samp;
  logic             div_rise;                     // Oscillator edge
  logic             sof_rise;                     // Frame start

  // Next-value logic
  always_comb begin
    div_rise  = sync2_ff & ~div_d_ff;
    sof_rise  = sof_i & ~sof_d_ff;
    nxt_div_d = sync2_ff;
    nxt_sof_d = sof_i;
    nxt_samp  = samp_ff;
    nxt_vld   = 1'b0;
    nxt_cnt   = cnt_ff;
    if (sof_rise) begin
      // Capture the completed period and restart
      nxt_samp = cnt_ff;                          // RULE20
      nxt_vld  = 1'b1;
      nxt_cnt  = '0;                              // RULE20
    end else if (div_rise && cnt_ff != '1) begin
      // One divided oscillator cycle seen
      nxt_cnt = cnt_ff + 1'b1;                    // RULE13
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      div_d_ff <= 1'b0;
      sof_d_ff <= 1'b0;
      cnt_ff   <= '0;
      samp_ff  <= '0;
      vld_ff   <= 1'b0;
    end else begin
      sync1_ff <= div_clk_i;
      sync2_ff <= sync1_ff;
      div_d_ff <= nxt_div_d;
      sof_d_ff <= nxt_sof_d;
      cnt_ff   <= nxt_cnt;
      samp_ff  <= nxt_samp;
      vld_ff   <= nxt_vld;
    end
  end

  assign sof_rise_o = sof_rise;
  assign live_o     = cnt_ff;
  assign sample_o   = samp_ff;
  assign valid_o    = vld_ff;

  // ============================================================
  // Checks
  // ============================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_count_clear: assert property (sof_rise |=> cnt_ff == '0 && vld_ff) // RULE20
    else $error("counter not cleared at frame start");
  a_count_capture: assert property (sof_rise |=> samp_ff == $past(cnt_ff)) // RULE20
    else $error("period count not captured");
  a_count_step: assert property (!sof_rise && !div_rise |=> $stable(cnt_ff)) // RULE13
    else $error("counter moved without an edge");

endmodule

// [hdl/accc_calibrator.sv]
`timescale 1ns/1ps
// Function
// RULE1: Frame pulse every 1 ms is timing reference
// RULE2: Aim oscillator at 48 MHz within 0.25%
// RULE3: Cross then return to nearest trim
// RULE4: Centre and boundary counts are programmable
// RULE5: Coarse or fine trim mode selectable
// RULE6: Done and lost flags, each own enable
// RULE7: Both requests share one interrupt output
// RULE8: Trim outputs stay internal, no pins
// RULE9: Coarse trim is eight bits wide
// RULE10: Fine trim is six bits wide
// RULE11: Fine trim resets to 32
// RULE12: Frame pulse high twelve clocks per ms
// RULE13: Count oscillator divided by six
// RULE14: Coarse step moves about 40 kHz
// RULE15: Fine step moves about 20 kHz
// RULE16: Step toward centre each period until crossed
// RULE17: Compare errors, step back if better, stop
// RULE18: Start on enable, recovery, or out-of-bounds
// RULE19: Step defaults one; zero freezes trims (STEP_I is an input here, no default)
// RULE20: Counter clears per frame, captures period
// ============================================================
// Calibrator top
// ============================================================
module accc_calibrator
  import accc_pkg::*;
(
  input  wire logic                       REF_CLK_I,         // 10 MHz system clock
  input  wire logic                       RST_B_I,           // Sync reset, low
  input  wire logic                       SOF_I,             // Frame reference
  input  wire logic                       DIV_CLK_I,         // Oscillator / 6
  input  wire logic                       CAL_ON_I,          // Calibration on
  input  wire logic                       FINE_MODE_I,       // 1 fine, 0 coarse
  input  wire logic [accc_pkg::STEP_W-1:0] STEP_I,           // Trim step
  input  wire logic [accc_pkg::CNT_W-1:0]  LOWER_BOUND_I,    // Lower bound count
  input  wire logic [accc_pkg::CNT_W-1:0]  CENTRE_I,         // Centre target
  input  wire logic [accc_pkg::CNT_W-1:0]  UPPER_BOUND_I,    // Upper bound count
  input  wire logic                       CAL_DONE_IRQ_EN_I, // Done request enable
  input  wire logic                       ERROR_IRQ_EN_I,    // Lost request enable
  input  wire logic                       CAL_DONE_CLR_I,    // Clear done flag
  input  wire logic                       REF_LOST_CLR_I,    // Clear lost flag
  output logic [accc_pkg::CT_W-1:0]       COARSE_TRIM_O,     // Coarse trim
  output logic [accc_pkg::FT_W-1:0]       FINE_TRIM_O,       // Fine trim
  output logic                            CAL_DONE_FLAG_O,   // Done flag
  output logic                            REF_LOST_FLAG_O,   // Lost flag
  output logic                            IRQ_O,             // Shared request
  output logic [accc_pkg::CNT_W-1:0]      SAMPLE_COUNT_O,    // Last period count
  output logic                            BUSY_O             // Search active
);
  import accc_pkg::*;

  // ============================================================
  // Sample counter
  // ============================================================
  logic             sof_rise;    // Frame start
  logic [CNT_W-1:0] live_cnt;    // Running count
  logic [CNT_W-1:0] samp;        // Completed period count
  logic             samp_vld;    // New period count

  // Counter runs off the frame reference
  accc_sample_counter i_accc_sample_counter (
    .clk_i      (REF_CLK_I),
    .rst_b_i    (RST_B_I),
    .div_clk_i  (DIV_CLK_I),
    .sof_i      (SOF_I),
    .sof_rise_o (sof_rise),
    .live_o     (live_cnt),
    .sample_o   (samp),
    .valid_o    (samp_vld)
  );

  // ============================================================
  // State
  // ============================================================
  accc_state_t      state_ff, nxt_state;      // Sequencer
  logic             up_ff, nxt_up;            // Search direction
  logic [CNT_W-1:0] err_prev_ff, nxt_err_prev;// Error before crossing
  logic [CT_W-1:0]  coarse_ff, nxt_coarse;    // Coarse trim
  logic [FT_W-1:0]  fine_ff, nxt_fine;        // Fine trim
  logic             done_ff, nxt_done;        // Done flag
  logic             lost_ff, nxt_lost;        // Lost flag
  logic             wait_ref_ff, nxt_wait_ref;// Reference gone
  logic             cal_d_ff;                 // Enable delayed
  logic [CNT_W-1:0] samp_ff;                  // Period count out

  // ============================================================
  // Decode helpers
  // ============================================================
  logic             above;       // Sample above centre
  logic             at_centre;   // Sample equals centre
  logic [CNT_W-1:0] err_now;     // Absolute error
  logic             out_bounds;  // Outside lower/upper
  logic             cal_rise;    // Enable rising edge
  logic             lost_now;    // Reference timed out
  logic [CNT_W:0]   lost_lim;    // Twice the centre
  logic             step_req;    // Move trim one step
  logic             step_dir;    // 1 raises frequency

  always_comb begin
    above      = samp > CENTRE_I;                              // RULE2
    at_centre  = samp == CENTRE_I;
    err_now    = above ? samp - CENTRE_I : CENTRE_I - samp; // RULE17
    out_bounds = samp < LOWER_BOUND_I || samp > UPPER_BOUND_I; // RULE4
    cal_rise   = CAL_ON_I & ~cal_d_ff;
    lost_lim   = {CENTRE_I, 1'b0};
    lost_now   = state_ff != ST_IDLE && !sof_rise &&
                 {1'b0, live_cnt} >= lost_lim;                 // RULE6
  end

  // ============================================================
  // Sequencer
  // ============================================================
  always_comb begin
    nxt_state    = state_ff;
    nxt_up       = up_ff;
    nxt_err_prev = err_prev_ff;
    nxt_wait_ref = wait_ref_ff;
    step_req     = 1'b0;
    step_dir     = up_ff;
    if (!CAL_ON_I) begin
      // Disabled: search abandoned
      nxt_state    = ST_IDLE;
      nxt_wait_ref = 1'b0;
    end else if (lost_now) begin
      // No frame within two centre counts
      nxt_state    = ST_IDLE;
      nxt_wait_ref = 1'b1;
    end else if (cal_rise) begin
      // Enable edge starts even when inside bounds
      nxt_state = ST_MEASURE;                                  // RULE18
    end else if (wait_ref_ff && samp_vld) begin
      // Reference back: skip the period that spanned the loss
      nxt_state    = ST_MEASURE;                               // RULE18
      nxt_wait_ref = 1'b0;
    end else if (samp_vld) begin
      case (state_ff)
        ST_IDLE: begin
          // Drift outside the window
          if (out_bounds) begin
            nxt_state = ST_MEASURE;                            // RULE18
          end
        end
        ST_MEASURE: begin
          // First full period picks the direction
          if (at_centre) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_up       = !above;                             // RULE16
            nxt_err_prev = err_now;
            step_req     = 1'b1;
            step_dir     = !above;
            nxt_state    = ST_CROSS;
          end
        end
        ST_CROSS: begin
          if ((up_ff && (above || at_centre)) ||
              (!up_ff && !above)) begin
            // Crossed: return if the old point was nearer
            if (err_prev_ff < err_now) begin
              step_req = 1'b1;                                 // RULE3
              step_dir = !up_ff;                               // RULE17
            end
            nxt_state = ST_IDLE;                               // RULE17
          end else begin
            // Keep stepping toward the centre
            nxt_err_prev = err_now;
            step_req     = 1'b1;                               // RULE16
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Trim update with saturation
  // ============================================================
  logic [CT_W:0] c_sum;  // Coarse plus step
  logic [FT_W:0] f_sum;  // Fine plus step

  always_comb begin
    nxt_coarse = coarse_ff;
    nxt_fine   = fine_ff;
    c_sum      = {1'b0, coarse_ff} + {{(CT_W+1-STEP_W){1'b0}}, STEP_I}; // RULE19
    f_sum      = {1'b0, fine_ff} + {{(FT_W+1-STEP_W){1'b0}}, STEP_I};
    if (step_req && !FINE_MODE_I) begin                        // RULE5
      // Coarse mode: one count ~40 kHz of divided clock
      if (step_dir) begin
        nxt_coarse = c_sum[CT_W] ? COARSE_MAX : c_sum[CT_W-1:0];  // RULE14
      end else if (coarse_ff < {{(CT_W-STEP_W){1'b0}}, STEP_I}) begin
        nxt_coarse = '0;
      end else begin
        nxt_coarse = coarse_ff - {{(CT_W-STEP_W){1'b0}}, STEP_I}; // RULE14
      end
    end else if (step_req) begin
      // Fine mode: one count ~20 kHz of divided clock
      if (step_dir) begin
        nxt_fine = f_sum[FT_W] ? FINE_MAX : f_sum[FT_W-1:0];      // RULE15
      end else if (fine_ff < {{(FT_W-STEP_W){1'b0}}, STEP_I}) begin
        nxt_fine = '0;
      end else begin
        nxt_fine = fine_ff - {{(FT_W-STEP_W){1'b0}}, STEP_I};    // RULE15
      end
    end
  end

  // ============================================================
  // Flags: hardware set beats software clear
  // ============================================================
  always_comb begin
    nxt_done = done_ff;
    nxt_lost = lost_ff;
    if (CAL_DONE_CLR_I) begin
      nxt_done = 1'b0;
    end
    if (state_ff == ST_CROSS && nxt_state == ST_IDLE && CAL_ON_I && !lost_now) begin
      nxt_done = 1'b1;                                         // RULE6
    end
    if (REF_LOST_CLR_I || !CAL_ON_I) begin
      nxt_lost = 1'b0;
    end
    if (lost_now && CAL_ON_I) begin
      nxt_lost = 1'b1;                                         // RULE6
    end
  end

  // ============================================================
  // Registers
  // ============================================================
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      state_ff    <= ST_IDLE;
      up_ff       <= 1'b0;
      err_prev_ff <= '0;
      coarse_ff   <= COARSE_RST;
      fine_ff     <= FINE_RST;                                 // RULE11
      done_ff     <= 1'b0;
      lost_ff     <= 1'b0;
      wait_ref_ff <= 1'b0;
      cal_d_ff    <= 1'b0;
      samp_ff     <= '0;
    end else begin
      state_ff    <= nxt_state;
      up_ff       <= nxt_up;
      err_prev_ff <= nxt_err_prev;
      coarse_ff   <= nxt_coarse;
      fine_ff     <= nxt_fine;
      done_ff     <= nxt_done;
      lost_ff     <= nxt_lost;
      wait_ref_ff <= nxt_wait_ref;
      cal_d_ff    <= CAL_ON_I;
      samp_ff     <= samp_vld ? samp : samp_ff;                // RULE1
    end
  end

  // ============================================================
  // Outputs, internal only
  // ============================================================
  assign COARSE_TRIM_O   = coarse_ff;                          // RULE8 RULE9
  assign FINE_TRIM_O     = fine_ff;                            // RULE8 RULE10
  assign CAL_DONE_FLAG_O = done_ff;
  assign REF_LOST_FLAG_O = lost_ff;
  assign IRQ_O           = (done_ff & CAL_DONE_IRQ_EN_I) |
                           (lost_ff & ERROR_IRQ_EN_I);         // RULE7
  assign SAMPLE_COUNT_O  = samp_ff;
  assign BUSY_O          = state_ff != ST_IDLE;

  // ============================================================
  // Checks
  // ============================================================
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_trim_on_sample: assert property (!$stable(coarse_ff) || !$stable(fine_ff) |-> $past(samp_vld)) // RULE1
    else $error("trim moved outside a period boundary");
  a_coarse_mode_only: assert property ($past(FINE_MODE_I) |-> $stable(coarse_ff)) // RULE5
    else $error("coarse trim moved in fine mode");
  a_fine_mode_only: assert property (!$past(FINE_MODE_I) |-> $stable(fine_ff)) // RULE5
    else $error("fine trim moved in coarse mode");
  a_step_zero_hold: assert property ($past(STEP_I) == '0 |-> $stable(coarse_ff) && $stable(fine_ff)) // RULE19
    else $error("trim moved with zero step");
  a_fine_reset_val: assert property ($rose(RST_B_I) |-> fine_ff == 6'h20) // RULE11
    else $error("fine trim reset value wrong");
  a_enable_starts: assert property (CAL_ON_I && !cal_d_ff && !lost_now |=> state_ff == ST_MEASURE) // RULE18
    else $error("enable edge did not start calibration");
  a_done_after_cross: assert property ($rose(done_ff) |-> $past(state_ff) == ST_CROSS && state_ff == ST_IDLE) // RULE17
    else $error("done flag without a finished search");
  a_lost_to_idle: assert property (lost_now |=> lost_ff && state_ff == ST_IDLE ##1 state_ff == ST_IDLE) // RULE6
    else $error("lost reference did not stop search");
  a_irq_from_done: assert property (done_ff && CAL_DONE_IRQ_EN_I |-> IRQ_O) // RULE7
    else $error("done request not on shared output");
  a_irq_needs_en: assert property (IRQ_O |-> (done_ff && CAL_DONE_IRQ_EN_I) || (lost_ff && ERROR_IRQ_EN_I)) // RULE6
    else $error("request raised without enable");
  a_step_up_first: assert property (state_ff == ST_MEASURE && samp_vld && !above && !at_centre && CAL_ON_I
    && !lost_now && !cal_rise && !(wait_ref_ff && samp_vld) && !FINE_MODE_I && STEP_I == 4'h1
    && coarse_ff != COARSE_MAX |=> coarse_ff == $past(coarse_ff) + 8'h01) // RULE16
    else $error("low count did not raise coarse trim");

  c_done_seen:  cover property ($rose(done_ff));
  c_lost_seen:  cover property ($rose(lost_ff));
  c_cross_down: cover property (state_ff == ST_CROSS && !up_ff ##1 state_ff == ST_IDLE);
  c_return:     cover property (state_ff == ST_CROSS && step_req && step_dir != up_ff);

endmodule

// [test/accc_far_model.sv]
`timescale 1ns/1ps
// ============================================================
// Far side: frame pulse source and trimmed oscillator
// ============================================================
module accc_far_model
  import accc_pkg::*;
#(
  parameter int  FRAME_CYC = SOF_PERIOD_CYC,  // Clocks between frame starts
  parameter real CLK_NS    = 100.0            // System clock period
)(
  input  wire logic            clk_i,         // System clock
  input  wire logic            sof_en_i,      // Low stops frames, fakes a lost reference
  input  wire logic [CT_W-1:0] coarse_i,      // Coarse trim from the calibrator
  input  wire logic [FT_W-1:0] fine_i,        // Fine trim from the calibrator
  output logic                 sof_o,         // Frame pulse
  output logic                 div_clk_o      // Oscillator divided by six
);
  int  cyc_cnt;  // Position within the frame
  int  counts;   // Divided edges per frame at present trims
  real half_ns;  // Half period of the divided clock

  // ============================================================
  // Frame pulse, changed on the falling edge
  // ============================================================
  initial begin
    cyc_cnt = 0;
    sof_o = 1'b0;
    forever begin
      @(negedge clk_i);
      sof_o = sof_en_i && (cyc_cnt < SOF_HIGH_CYC);
      cyc_cnt = (cyc_cnt + 1) % FRAME_CYC;
    end
  end

  // ============================================================
  // Oscillator: coarse unit is twice a fine unit, rising with the trim
  // ============================================================
  initial begin
    div_clk_o = 1'b0;
    forever begin
      counts = 400 + 16 * (int'(coarse_i) - 128) + 8 * (int'(fine_i) - 32);
      // Guard against unknown trims before reset lands
      if (counts < 100) begin
        counts = 100;
      end
      half_ns = (FRAME_CYC * CLK_NS) / (2.0 * counts);
      #(half_ns) div_clk_o = ~div_clk_o;
    end
  end
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
// ============================================================
// Bench for the auto clock calibrator
// ============================================================
module tb;
  import accc_pkg::*;

  localparam int FRAME = 2500;  // Shortened frame keeps the run brief

  logic              ref_clk, rst_b, sof, div_clk, sof_en;  // Clock, reset, far side
  logic              cal_on, fine_mode, done_en, err_en;    // Control levels
  logic              done_clr, lost_clr;                    // Flag clears
  logic [STEP_W-1:0] step;                                  // Trim step
  logic [CNT_W-1:0]  lower, centre, upper, sample;          // Thresholds and count
  logic [CT_W-1:0]   coarse;                                // Coarse trim seen
  logic [FT_W-1:0]   fine;                                  // Fine trim seen
  logic              done_flag, lost_flag, irq, busy;       // Status seen
  int                error_cnt, samples_checked;            // Tallies

  // Device under test
  accc_calibrator i_accc_calibrator (
    .REF_CLK_I(ref_clk), .RST_B_I(rst_b), .SOF_I(sof), .DIV_CLK_I(div_clk),
    .CAL_ON_I(cal_on), .FINE_MODE_I(fine_mode), .STEP_I(step),
    .LOWER_BOUND_I(lower), .CENTRE_I(centre), .UPPER_BOUND_I(upper),
    .CAL_DONE_IRQ_EN_I(done_en), .ERROR_IRQ_EN_I(err_en),
    .CAL_DONE_CLR_I(done_clr), .REF_LOST_CLR_I(lost_clr),
    .COARSE_TRIM_O(coarse), .FINE_TRIM_O(fine), .CAL_DONE_FLAG_O(done_flag),
    .REF_LOST_FLAG_O(lost_flag), .IRQ_O(irq), .SAMPLE_COUNT_O(sample), .BUSY_O(busy));

  // Frame source and oscillator
  accc_far_model #(.FRAME_CYC(FRAME)) i_accc_far_model (
    .clk_i(ref_clk), .sof_en_i(sof_en), .coarse_i(coarse), .fine_i(fine),
    .sof_o(sof), .div_clk_o(div_clk));

  // ============================================================
  // Clock and watchdog
  // ============================================================
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #(100 * 60000);
    error_cnt++;
    give_verdict();
  end

  // ============================================================
  // Tasks
  // ============================================================
  // Compare and tally
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // Print verdict and stop
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Wait, bounded, until the search flag reaches a level
  task automatic wait_busy(input logic want);
    int n;
    n = 0;
    while (busy !== want && n < 8 * FRAME) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 8 * FRAME) begin
      error_cnt++;
      $display("CHECK FAILED at %0t ns: busy never reached %0b", $time, want);
    end
    @(negedge ref_clk);
  endtask

  // Drop and raise the enable to start a search
  task automatic restart();
    @(negedge ref_clk);
    cal_on = 1'b0;
    @(negedge ref_clk);
    cal_on = 1'b1;
    @(negedge ref_clk);
    @(negedge ref_clk);
  endtask

  // One-cycle pulse on the clear of the done flag
  task automatic clear_done();
    @(negedge ref_clk);
    done_clr = 1'b1;
    @(negedge ref_clk);
    done_clr = 1'b0;
    @(negedge ref_clk);
  endtask

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    rst_b = 1'b0;
    sof_en = 1'b1;
    cal_on = 1'b0;
    fine_mode = 1'b0;
    done_en = 1'b1;
    err_en = 1'b0;
    done_clr = 1'b0;
    lost_clr = 1'b0;
    step = 4'h1;
    lower = 16'h0000;
    centre = 16'd420;
    upper = 16'hFFFF;
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    // Reset state
    check(16'(coarse), 16'h0080, "coarse after reset");
    check(16'(fine), 16'h0020, "fine after reset");
    check(16'({done_flag, lost_flag, irq, busy}), 16'h0000, "status after reset");
    // Coarse search upward: 400, 416, 432 then back one step
    restart();
    check(16'(busy), 16'h0001, "busy on enable rise");
    wait_busy(1'b0);
    check(16'(coarse), 16'h0081, "coarse after up search");
    check(16'(fine), 16'h0020, "fine untouched in coarse mode");
    check(16'(done_flag), 16'h0001, "done flag");
    check(16'(irq), 16'h0001, "request on done");
    check(16'(sample >= 16'd431 && sample <= 16'd433), 16'h0001, "captured count");
    clear_done();
    check(16'({done_flag, irq}), 16'h0000, "done cleared");
    // Fine search downward: 416, 408, 400 keeps the later trim
    fine_mode = 1'b1;
    done_en = 1'b0;
    centre = 16'd403;
    restart();
    wait_busy(1'b0);
    check(16'(fine), 16'h001E, "fine after down search");
    check(16'(coarse), 16'h0081, "coarse untouched in fine mode");
    check(16'({done_flag, irq}), 16'h0002, "done set, request masked");
    clear_done();
    // Count above the upper bound starts a search with the enable held
    lower = 16'd380;
    centre = 16'd390;
    upper = 16'd395;
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(16'(fine), 16'h001D, "fine after bound trigger");
    check(16'(done_flag), 16'h0001, "done after bound trigger");
    clear_done();
    // Step of zero leaves both trims frozen while searching
    step = 4'h0;
    centre = 16'd500;
    upper = 16'hFFFF;
    lower = 16'h0000;
    restart();
    repeat (3 * FRAME) @(negedge ref_clk);
    check(16'({coarse, 2'b00, fine}), 16'h811D, "trims frozen at step zero");
    check(16'(busy), 16'h0001, "search still running");
    cal_on = 1'b0;
    @(negedge ref_clk);
    @(negedge ref_clk);
    check(16'(busy), 16'h0000, "enable low aborts");
    // Lost reference while searching
    step = 4'h1;
    err_en = 1'b1;
    centre = 16'd100;
    sof_en = 1'b0;
    restart();
    wait_busy(1'b0);
    check(16'({lost_flag, irq}), 16'h0003, "lost flag and request");
    err_en = 1'b0;
    @(negedge ref_clk);
    check(16'(irq), 16'h0000, "lost request masked");
    // Recovery of the reference restarts the search
    centre = 16'd250;
    sof_en = 1'b1;
    wait_busy(1'b1);
    check(16'(busy), 16'h0001, "search after recovery");
    @(negedge ref_clk);
    lost_clr = 1'b1;
    @(negedge ref_clk);
    lost_clr = 1'b0;
    @(negedge ref_clk);
    check(16'(lost_flag), 16'h0000, "lost flag cleared");
    cal_on = 1'b0;
    repeat (2) @(negedge ref_clk);
    give_verdict();
  end
endmodule
